// ---- shared/fspd_pkg.sv ----
// Purpose: Shared constants and types for the flash suspend / power-down command block
// Assumes: 50 MHz core clock; host drives chip select, serial clock and data in
// Notes:   Times are in ns; cycle counts derive from them and the clock period
package fspd_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_NS = 20;
	localparam int SUSPEND_LAT_NS = 20000;
	localparam int RESUME_NS = 200;
	localparam int SLEEP_ENTRY_DELAY_NS = 3000;
	localparam int WAKE_DELAY_NS = 3000;
	localparam int WAKE_WITH_ID_DELAY_NS = 8800;
	localparam int SW_RESET_NS = 30000;
	localparam int PROG_NS = 600000;
	localparam int ERASE_NS = 45000000;
	localparam int WRSR_NS = 2000000;
	// Longest times round down, least times round up, never below one cycle
	localparam int SUSPEND_LAT_CYC = (SUSPEND_LAT_NS / CLK_NS < 1) ? 1 : SUSPEND_LAT_NS / CLK_NS;
	localparam int RESUME_CYC = (RESUME_NS / CLK_NS < 1) ? 1 : RESUME_NS / CLK_NS;
	localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int WAKE_CYC = (WAKE_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int WAKE_ID_CYC = (WAKE_WITH_ID_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int SW_RESET_CYC = (SW_RESET_NS + CLK_NS - 1) / CLK_NS;
	localparam int PROG_CYC = (PROG_NS + CLK_NS - 1) / CLK_NS;
	localparam int ERASE_CYC = (ERASE_NS + CLK_NS - 1) / CLK_NS;
	localparam int WRSR_CYC = (WRSR_NS + CLK_NS - 1) / CLK_NS;
	localparam int OP_CNT_W = 24;
	localparam int PWR_CNT_W = 12;
	localparam int LAT_CNT_W = 12;

	// ----------------------------------------------------------------
	// Frame lengths in serial clock edges
	// ----------------------------------------------------------------
	localparam logic [6:0] BITS_OPCODE = 7'h08;
	localparam logic [6:0] BITS_WRSR = 7'h10;
	localparam logic [6:0] BITS_ADDR = 7'h20;
	localparam logic [6:0] BITS_DATA = 7'h28;
	localparam logic [6:0] BITS_MAX = 7'h7F;

	// ----------------------------------------------------------------
	// Opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] OPC_SUSPEND = 8'h75;
	localparam logic [7:0] OPC_RESUME = 8'h7A;
	localparam logic [7:0] OPC_DEEP_SLEEP = 8'hB9;
	localparam logic [7:0] OPC_WAKE_READ_ID = 8'hAB;
	localparam logic [7:0] OPC_DISCOVERABLE = 8'h5A;
	localparam logic [7:0] OPC_READ = 8'h03;
	localparam logic [7:0] OPC_FAST_READ = 8'h0B;
	localparam logic [7:0] OPC_RESET_ENABLE = 8'h66;
	localparam logic [7:0] OPC_RESET = 8'h99;
	localparam logic [7:0] OPC_WRSR1 = 8'h01;
	localparam logic [7:0] OPC_WRSR2 = 8'h31;
	localparam logic [7:0] OPC_WRSR3 = 8'h11;
	localparam logic [7:0] OPC_SEC_ERASE = 8'h44;
	localparam logic [7:0] OPC_SEC_PROG = 8'h42;
	localparam logic [7:0] OPC_PP = 8'h02;
	localparam logic [7:0] OPC_PP4 = 8'h12;
	localparam logic [7:0] OPC_QPP = 8'h32;
	localparam logic [7:0] OPC_QPP4 = 8'h34;
	localparam logic [7:0] OPC_SE = 8'h20;
	localparam logic [7:0] OPC_SE4 = 8'h21;
	localparam logic [7:0] OPC_BE32 = 8'h52;
	localparam logic [7:0] OPC_BE32_4 = 8'h5C;
	localparam logic [7:0] OPC_BE64 = 8'hD8;
	localparam logic [7:0] OPC_BE64_4 = 8'hDC;
	localparam logic [7:0] OPC_CE1 = 8'hC7;
	localparam logic [7:0] OPC_CE2 = 8'h60;

	// ----------------------------------------------------------------
	// Status layout
	// ----------------------------------------------------------------
	localparam int ST_WRITE_IN_PROGRESS = 0;
	localparam int ST_SUS_ERASE = 10;
	localparam int ST_SUS_PROG = 15;
	localparam int ST_DRIVE_STRENGTH0 = 21;
	localparam logic [23:0] STATUS_RESET = 24'h200000;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {PWR_ACTIVE, PWR_ENTER, PWR_SLEEP, PWR_WAKE, PWR_RESET} fspd_pwr_e;
	typedef enum logic [1:0] {OP_NONE, OP_PROG, OP_ERASE, OP_WRSR} fspd_op_e;
	typedef enum logic [1:0] {LAT_NONE, LAT_SUS, LAT_RES} fspd_lat_e;
	typedef struct packed {
		logic [7:0] opcode;
		logic [6:0] bits;
	} fspd_frame_s;

endpackage

// ---- rtl/fspd_ctrl.sv ----
// Purpose: Suspend/resume, deep sleep, wake/identifier and table read handling of a serial flash
// Assumes: Host keeps serial clock still while deselected; frames decoded after deselect
// Notes:   Functional notes follow
// Functional notes
// - Opcode 75H suspends a running program or erase.
// - During program suspend refuse status writes, security erase/program, erases, programs.
// - During erase suspend refuse status writes, security erase and all erases.
// - Suspend taken only with suspend flags clear and write-in-progress set.
// - Accepted suspend sets its flag at once, drops write-in-progress within latency.
// - Resume 7AH taken only with a suspend flag set and write-in-progress clear.
// - Resume clears flags, sets write-in-progress within 200ns, finishes the operation.
// - In deep sleep only wake/identifier and software reset are obeyed.
// - Deep sleep executes only when chip select rises right after eight bits.
// - Lowest-power mode starts only after the sleep entry delay.
// - Deep sleep command during a running cycle is rejected.
// - Deselect gives standby, never deep sleep, and only when idle.
// - Power-up reset always starts in standby, never deep sleep.
// - Bare ABH wakes the device after the wake delay.
// - ABH plus three dummy bytes shifts the identifier out repeatedly, MSB first.
// - Identifier read from deep sleep wakes after the longer delay.
// - Wake/identifier command ignored while write-in-progress is set.
// - Opcode 5AH reads the internal parameter tables.
// - Array bytes read FFH; status resets to zero except drive bit.
// - Software reset aborts operations, clears suspend and deep sleep.
`timescale 1ns/1ns
`default_nettype none

module fspd_ctrl #(
	parameter int PROG_CYCLES = fspd_pkg::PROG_CYC,
	parameter int ERASE_CYCLES = fspd_pkg::ERASE_CYC,
	parameter int WRSR_CYCLES = fspd_pkg::WRSR_CYC,
	// Identifier value is arbitrary
	parameter logic [7:0] ID_VALUE = 8'h3C
) (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic SCLK,
	input wire logic CS_N,
	input wire logic SI,
	output logic SO,
	output logic SO_OE,
	output logic [23:0] STATUS,
	output logic DEEP_SLEEP,
	output logic STANDBY
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic is_prog(input logic [7:0] op);
		return op == fspd_pkg::OPC_PP || op == fspd_pkg::OPC_PP4 || op == fspd_pkg::OPC_QPP
			|| op == fspd_pkg::OPC_QPP4 || op == fspd_pkg::OPC_SEC_PROG;
	endfunction

	function automatic logic is_erase(input logic [7:0] op, input logic [6:0] n);
		logic addr_erase;
		logic chip_erase;
		addr_erase = op == fspd_pkg::OPC_SE || op == fspd_pkg::OPC_SE4 || op == fspd_pkg::OPC_BE32
			|| op == fspd_pkg::OPC_BE32_4 || op == fspd_pkg::OPC_BE64
			|| op == fspd_pkg::OPC_BE64_4 || op == fspd_pkg::OPC_SEC_ERASE;
		chip_erase = op == fspd_pkg::OPC_CE1 || op == fspd_pkg::OPC_CE2;
		return (addr_erase && n == fspd_pkg::BITS_ADDR) || (chip_erase && n == fspd_pkg::BITS_OPCODE);
	endfunction

	function automatic logic [7:0] table_byte(input logic [2:0] idx);
		case (idx)
			3'h0: return 8'h53;
			3'h1: return 8'h46;
			3'h2: return 8'h44;
			3'h3: return 8'h50;
			3'h4: return 8'h06;
			3'h5: return 8'h01;
			3'h6: return 8'h00;
			default: return 8'hFF;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Link domain: shift in
	// ----------------------------------------------------------------
	logic fresh;
	logic [6:0] bits;
	logic [2:0] phase;
	logic [2:0] rd_byte;
	logic [31:0] shreg;
	logic [7:0] opcode;
	logic [23:0] addr;
	logic frame_tog;
	logic [1:0] busy_l1;
	logic [1:0] busy_l2;

	// Set while deselected so the first edge of a frame restarts counting
	always_ff @(posedge SCLK or posedge CS_N or negedge RSTN) begin
		if (!RSTN)
			fresh <= 1'b1;
		else if (CS_N)
			fresh <= 1'b1;
		else
			fresh <= 1'b0;
	end

	// Frame registers hold after deselect so the core can read them undisturbed
	always_ff @(posedge SCLK or negedge RSTN) begin
		if (!RSTN) begin
			bits <= 7'h00;
			phase <= 3'h0;
			rd_byte <= 3'h0;
			shreg <= 32'h00000000;
			opcode <= 8'h00;
			addr <= 24'h000000;
			frame_tog <= 1'b0;
		end else if (fresh) begin
			bits <= 7'h01;
			phase <= 3'h1;
			rd_byte <= 3'h0;
			shreg <= {31'h00000000, SI};
			frame_tog <= ~frame_tog;
		end else begin
			if (bits != fspd_pkg::BITS_MAX)
				bits <= bits + 7'h01;
			phase <= phase + 3'h1;
			shreg <= {shreg[30:0], SI};
			if (bits == fspd_pkg::BITS_OPCODE - 7'h01)
				opcode <= {shreg[6:0], SI};
			if (bits == fspd_pkg::BITS_ADDR - 7'h01)
				addr <= {shreg[22:0], SI};
			if (phase == 3'h7 && bits >= fspd_pkg::BITS_DATA)
				rd_byte <= rd_byte + 3'h1;
		end
	end

	// Core state into the link domain; bit 0 busy, bit 1 not in the active power state
	logic [1:0] core_flags;
	always_ff @(posedge SCLK or negedge RSTN) begin
		if (!RSTN) begin
			busy_l1 <= 2'h0;
			busy_l2 <= 2'h0;
		end else begin
			busy_l1 <= core_flags;
			busy_l2 <= busy_l1;
		end
	end

	// ----------------------------------------------------------------
	// Link domain: shift out on falling edges
	// ----------------------------------------------------------------
	logic [7:0] table_out;
	assign table_out = table_byte(addr[2:0] + rd_byte);

	always_ff @(negedge SCLK or posedge CS_N or negedge RSTN) begin
		if (!RSTN) begin
			SO <= 1'b0;
			SO_OE <= 1'b0;
		end else if (CS_N) begin
			SO <= 1'b0;
			SO_OE <= 1'b0;
		end else begin
			SO <= 1'b0;
			SO_OE <= 1'b0;
			if (opcode == fspd_pkg::OPC_WAKE_READ_ID && bits >= fspd_pkg::BITS_ADDR && !busy_l2[0]) begin
				SO <= ID_VALUE[~phase];
				SO_OE <= 1'b1;
			end
			if (opcode == fspd_pkg::OPC_DISCOVERABLE && bits >= fspd_pkg::BITS_DATA && !busy_l2[1]) begin
				SO <= table_out[~phase];
				SO_OE <= 1'b1;
			end
			if (!busy_l2[1] && ((opcode == fspd_pkg::OPC_READ && bits >= fspd_pkg::BITS_ADDR)
				|| (opcode == fspd_pkg::OPC_FAST_READ && bits >= fspd_pkg::BITS_DATA))) begin
				SO <= fspd_pkg::ERASED_BYTE[~phase];
				SO_OE <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Core domain: frame end detection
	// ----------------------------------------------------------------
	logic cs_s1;
	logic cs_s2;
	logic cs_s3;
	logic tog_s1;
	logic tog_s2;
	logic tog_seen;
	logic frame_end;
	fspd_pkg::fspd_frame_s frm;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			cs_s3 <= 1'b1;
			tog_s1 <= 1'b0;
			tog_s2 <= 1'b0;
			tog_seen <= 1'b0;
		end else begin
			cs_s1 <= CS_N;
			cs_s2 <= cs_s1;
			cs_s3 <= cs_s2;
			tog_s1 <= frame_tog;
			tog_s2 <= tog_s1;
			if (cs_s2 && !cs_s3)
				tog_seen <= tog_s2;
		end
	end

	// A deselect with no clock edges carries no command
	assign frame_end = cs_s2 && !cs_s3 && (tog_s2 != tog_seen);
	// Link registers are still while deselected, so reading them here is safe
	assign frm = '{opcode: opcode, bits: bits};

	// ----------------------------------------------------------------
	// Core domain: command decode
	// ----------------------------------------------------------------
	fspd_pkg::fspd_pwr_e pwr;
	fspd_pkg::fspd_op_e run_kind;
	fspd_pkg::fspd_op_e held_kind;
	fspd_pkg::fspd_lat_e lat_mode;
	logic [fspd_pkg::OP_CNT_W-1:0] run_cnt;
	logic [fspd_pkg::OP_CNT_W-1:0] held_cnt;
	logic [fspd_pkg::LAT_CNT_W-1:0] lat_cnt;
	logic [fspd_pkg::PWR_CNT_W-1:0] pwr_cnt;
	logic write_in_progress;
	logic sus_prog;
	logic sus_erase;
	logic rst_armed;
	logic ready;
	logic acc_sus;
	logic acc_res;
	logic acc_prog;
	logic acc_erase;
	logic acc_wrsr;
	logic acc_sleep;
	logic acc_wake;
	logic acc_reset;
	logic lat_done;
	logic run_done;

	assign core_flags = {pwr != fspd_pkg::PWR_ACTIVE, write_in_progress};
	assign lat_done = lat_mode != fspd_pkg::LAT_NONE && lat_cnt == fspd_pkg::LAT_CNT_W'(1);
	assign run_done = run_kind != fspd_pkg::OP_NONE && run_cnt <= fspd_pkg::OP_CNT_W'(1);

	always_comb begin
		// only active state obeys ordinary commands
		ready = frame_end && pwr == fspd_pkg::PWR_ACTIVE && lat_mode == fspd_pkg::LAT_NONE;
		acc_sus = ready && frm.opcode == fspd_pkg::OPC_SUSPEND && frm.bits == fspd_pkg::BITS_OPCODE
			&& write_in_progress && !sus_prog && !sus_erase
			&& (run_kind == fspd_pkg::OP_PROG || run_kind == fspd_pkg::OP_ERASE);
		acc_res = ready && frm.opcode == fspd_pkg::OPC_RESUME && frm.bits == fspd_pkg::BITS_OPCODE
			&& !write_in_progress && (sus_prog || sus_erase);
		acc_prog = ready && is_prog(frm.opcode) && frm.bits >= fspd_pkg::BITS_DATA
			&& !write_in_progress && !sus_prog;
		acc_erase = ready && is_erase(frm.opcode, frm.bits) && !write_in_progress
			&& !sus_prog && !sus_erase;
		acc_wrsr = ready && frm.bits >= fspd_pkg::BITS_WRSR && !write_in_progress
			&& !sus_prog && !sus_erase
			&& (frm.opcode == fspd_pkg::OPC_WRSR1 || frm.opcode == fspd_pkg::OPC_WRSR2
			|| frm.opcode == fspd_pkg::OPC_WRSR3);
		acc_sleep = ready && frm.opcode == fspd_pkg::OPC_DEEP_SLEEP && frm.bits == fspd_pkg::BITS_OPCODE
			&& !write_in_progress;
		acc_wake = frame_end && frm.opcode == fspd_pkg::OPC_WAKE_READ_ID && !write_in_progress
			&& frm.bits >= fspd_pkg::BITS_OPCODE
			&& (pwr == fspd_pkg::PWR_SLEEP || pwr == fspd_pkg::PWR_ENTER);
		acc_reset = frame_end && rst_armed && frm.opcode == fspd_pkg::OPC_RESET
			&& frm.bits == fspd_pkg::BITS_OPCODE
			&& pwr != fspd_pkg::PWR_RESET && pwr != fspd_pkg::PWR_WAKE;
	end

	// Reset needs an enable frame immediately before it
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN)
			rst_armed <= 1'b0;
		else if (frame_end)
			rst_armed <= frm.opcode == fspd_pkg::OPC_RESET_ENABLE && frm.bits == fspd_pkg::BITS_OPCODE
				&& pwr != fspd_pkg::PWR_RESET && pwr != fspd_pkg::PWR_WAKE;
	end

	// ----------------------------------------------------------------
	// Core domain: internal operation and suspend
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			write_in_progress <= 1'b0;
			run_kind <= fspd_pkg::OP_NONE;
			run_cnt <= '0;
		end else if (acc_reset) begin
			write_in_progress <= 1'b0;
			run_kind <= fspd_pkg::OP_NONE;
			run_cnt <= '0;
		end else if (acc_prog) begin
			write_in_progress <= 1'b1;
			run_kind <= fspd_pkg::OP_PROG;
			run_cnt <= fspd_pkg::OP_CNT_W'(PROG_CYCLES);
		end else if (acc_erase) begin
			write_in_progress <= 1'b1;
			run_kind <= fspd_pkg::OP_ERASE;
			run_cnt <= fspd_pkg::OP_CNT_W'(ERASE_CYCLES);
		end else if (acc_wrsr) begin
			write_in_progress <= 1'b1;
			run_kind <= fspd_pkg::OP_WRSR;
			run_cnt <= fspd_pkg::OP_CNT_W'(WRSR_CYCLES);
		end else if (acc_sus) begin
			// Work stops now; the busy bit follows after the latency
			run_kind <= fspd_pkg::OP_NONE;
		end else if (lat_done) begin
			write_in_progress <= lat_mode == fspd_pkg::LAT_RES;
			if (lat_mode == fspd_pkg::LAT_RES) begin
				run_kind <= held_kind;
				run_cnt <= held_cnt;
			end
		end else if (run_done) begin
			write_in_progress <= 1'b0;
			run_kind <= fspd_pkg::OP_NONE;
		end else if (run_kind != fspd_pkg::OP_NONE) begin
			run_cnt <= run_cnt - fspd_pkg::OP_CNT_W'(1);
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			sus_prog <= 1'b0;
			sus_erase <= 1'b0;
			held_kind <= fspd_pkg::OP_NONE;
			held_cnt <= '0;
		end else if (acc_reset) begin
			sus_prog <= 1'b0;
			sus_erase <= 1'b0;
			held_kind <= fspd_pkg::OP_NONE;
		end else if (acc_sus) begin
			sus_prog <= run_kind == fspd_pkg::OP_PROG;
			sus_erase <= run_kind == fspd_pkg::OP_ERASE;
			held_kind <= run_kind;
			held_cnt <= run_cnt;
		end else if (acc_res) begin
			sus_prog <= 1'b0;
			sus_erase <= 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			lat_mode <= fspd_pkg::LAT_NONE;
			lat_cnt <= '0;
		end else if (acc_reset) begin
			lat_mode <= fspd_pkg::LAT_NONE;
		end else if (acc_sus) begin
			lat_mode <= fspd_pkg::LAT_SUS;
			lat_cnt <= fspd_pkg::LAT_CNT_W'(fspd_pkg::SUSPEND_LAT_CYC);
		end else if (acc_res) begin
			lat_mode <= fspd_pkg::LAT_RES;
			lat_cnt <= fspd_pkg::LAT_CNT_W'(fspd_pkg::RESUME_CYC);
		end else if (lat_done) begin
			lat_mode <= fspd_pkg::LAT_NONE;
		end else if (lat_mode != fspd_pkg::LAT_NONE) begin
			lat_cnt <= lat_cnt - fspd_pkg::LAT_CNT_W'(1);
		end
	end

	// ----------------------------------------------------------------
	// Core domain: power state
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			pwr <= fspd_pkg::PWR_ACTIVE;
			pwr_cnt <= '0;
		end else if (acc_reset) begin
			pwr <= fspd_pkg::PWR_RESET;
			pwr_cnt <= fspd_pkg::PWR_CNT_W'(fspd_pkg::SW_RESET_CYC);
		end else begin
			case (pwr)
				fspd_pkg::PWR_ACTIVE: begin
					if (acc_sleep) begin
						pwr <= fspd_pkg::PWR_ENTER;
						pwr_cnt <= fspd_pkg::PWR_CNT_W'(fspd_pkg::SLEEP_ENTRY_CYC);
					end
				end
				fspd_pkg::PWR_ENTER, fspd_pkg::PWR_SLEEP: begin
					if (acc_wake) begin
						pwr <= fspd_pkg::PWR_WAKE;
						if (frm.bits >= fspd_pkg::BITS_ADDR)
							pwr_cnt <= fspd_pkg::PWR_CNT_W'(fspd_pkg::WAKE_ID_CYC);
						else
							pwr_cnt <= fspd_pkg::PWR_CNT_W'(fspd_pkg::WAKE_CYC);
					end else if (pwr == fspd_pkg::PWR_ENTER) begin
						// lowest power only after entry delay
						if (pwr_cnt <= fspd_pkg::PWR_CNT_W'(1))
							pwr <= fspd_pkg::PWR_SLEEP;
						else
							pwr_cnt <= pwr_cnt - fspd_pkg::PWR_CNT_W'(1);
					end
				end
				fspd_pkg::PWR_WAKE, fspd_pkg::PWR_RESET: begin
					if (pwr_cnt <= fspd_pkg::PWR_CNT_W'(1))
						pwr <= fspd_pkg::PWR_ACTIVE;
					else
						pwr_cnt <= pwr_cnt - fspd_pkg::PWR_CNT_W'(1);
				end
				default: begin
					pwr <= fspd_pkg::PWR_ACTIVE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Core domain: outputs
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			// drive bit set, all else clear
			STATUS <= fspd_pkg::STATUS_RESET;
			DEEP_SLEEP <= 1'b0;
			STANDBY <= 1'b0;
		end else begin
			STATUS <= fspd_pkg::STATUS_RESET;
			STATUS[fspd_pkg::ST_WRITE_IN_PROGRESS] <= write_in_progress;
			STATUS[fspd_pkg::ST_SUS_PROG] <= sus_prog;
			STATUS[fspd_pkg::ST_SUS_ERASE] <= sus_erase;
			DEEP_SLEEP <= pwr == fspd_pkg::PWR_SLEEP;
			// standby only when deselected and idle
			STANDBY <= cs_s2 && !write_in_progress && pwr == fspd_pkg::PWR_ACTIVE
				&& lat_mode == fspd_pkg::LAT_NONE;
		end
	end

endmodule

`default_nettype wire

// ---- bench/fspd_checker.sv ----
// Purpose: Port assertions for the suspend and deep sleep block
// Assumes: All checks sampled on the core clock
// Notes: Bound to every fspd_ctrl instance
`timescale 1ns/1ns
`default_nettype none
module fspd_checker (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic SCLK,
	input wire logic CS_N,
	input wire logic SI,
	input wire logic SO,
	input wire logic SO_OE,
	input wire logic [23:0] STATUS,
	input wire logic DEEP_SLEEP,
	input wire logic STANDBY
);
	logic [11:0] hi_cnt;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	// Saturates so a long idle spell never wraps
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN)
			hi_cnt <= 12'h000;
		else if (!CS_N)
			hi_cnt <= 12'h000;
		else if (hi_cnt != 12'hFFF)
			hi_cnt <= hi_cnt + 12'h001;
	end
	sequence sus_set;
		$rose(STATUS[15] | STATUS[10]);
	endsequence
	sequence res_clr;
		$fell(STATUS[15] | STATUS[10]);
	endsequence
	drive_bit_a: assert property (STATUS[21])
		else $error("drive bit low");
	unused_zero_a: assert property ((STATUS & ~24'h208401) == 24'h0)
		else $error("unused status bit set");
	one_flag_a: assert property (!(STATUS[15] && STATUS[10]))
		else $error("both suspend flags set");
	sus_cause_a: assert property (sus_set |-> $past(STATUS[0]))
		else $error("suspend while idle");
	sus_lat_a: assert property (sus_set |-> ##[0:1000] !STATUS[0])
		else $error("suspend latency exceeded");
	res_cause_a: assert property (res_clr |-> !$past(STATUS[0]))
		else $error("resume while busy");
	res_busy_a: assert property (res_clr |-> ##[1:10] STATUS[0])
		else $error("resume did not restart");
	sleep_idle_a: assert property (DEEP_SLEEP |-> !STATUS[0])
		else $error("asleep while busy");
	sleep_dly_a: assert property ($rose(DEEP_SLEEP) |-> hi_cnt >= fspd_pkg::SLEEP_ENTRY_CYC)
		else $error("sleep entered early");
	standby_busy_a: assert property (STATUS[0] && $past(STATUS[0]) |-> !STANDBY)
		else $error("standby while busy");
	oe_desel_a: assert property (CS_N |-> !SO_OE)
		else $error("output driven while deselected");
endmodule
bind fspd_ctrl fspd_checker u_chk (.CLK(CLK), .RSTN(RSTN), .SCLK(SCLK), .CS_N(CS_N),
	.SI(SI), .SO(SO), .SO_OE(SO_OE), .STATUS(STATUS), .DEEP_SLEEP(DEEP_SLEEP),
	.STANDBY(STANDBY));
`default_nettype wire

// ---- bench/fspd_host.sv ----
// Purpose: Host controller model issuing command frames
// Assumes: Serial clock idles low and stands still between frames
// Notes: Read bits are sampled on the rising serial clock edge
`timescale 1ns/1ns
`default_nettype none
module fspd_host (
	output logic CS_N,
	output logic SCLK,
	output logic SI,
	input wire logic SO
);
	initial begin
		CS_N = 1'b1;
		SCLK = 1'b0;
		SI = 1'b0;
	end
	task automatic frame(input logic [63:0] d, input int n, input int nr,
		output logic [15:0] rd);
		rd = 16'h0000;
		CS_N = 1'b0;
		#16;
		for (int i = 0; i < n + nr; i++) begin
			SI = (i < n) ? d[63 - i] : ~SI;
			#16 SCLK = 1'b1;
			if (i >= n)
				rd = {rd[14:0], SO};
			#16 SCLK = 1'b0;
		end
		#16 CS_N = 1'b1;
		// Released data line must not look like a held value
		SI = ~SI;
		#100;
	endtask
endmodule
`default_nettype wire

// ---- bench/fspd_ctrl_tb.sv ----
// Purpose: Self-checking bench for suspend, deep sleep and identifier reads
// Assumes: Short program and erase counts
// Notes: Host model paces frames on the 32 ns serial clock
`timescale 1ns/1ns
`default_nettype none
module fspd_ctrl_tb;
	logic CLK = 1'b0;
	logic RSTN = 1'b0;
	wire logic CS_N, SCLK, SI, SO, SO_OE, DEEP_SLEEP, STANDBY;
	wire logic [23:0] STATUS;
	logic [15:0] rd;
	int n_errors = 0;
	int check_count = 0;
	int cyc = 0;
	int oe_cnt = 0;
	// Counts link edges at which the device drives its data line
	always @(posedge SCLK)
		if (SO_OE === 1'b1)
			oe_cnt++;
	always #10 CLK = ~CLK;
	fspd_ctrl #(.PROG_CYCLES(400), .ERASE_CYCLES(800), .WRSR_CYCLES(20)) u_dut (.CLK(CLK),
		.RSTN(RSTN), .SCLK(SCLK), .CS_N(CS_N), .SI(SI), .SO(SO), .SO_OE(SO_OE),
		.STATUS(STATUS), .DEEP_SLEEP(DEEP_SLEEP), .STANDBY(STANDBY));
	fspd_host u_host (.CS_N(CS_N), .SCLK(SCLK), .SI(SI), .SO(SO));
	task automatic wt(input int n);
		repeat (n) @(negedge CLK);
	endtask
	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		check_count++;
		if (g !== e) begin
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
			n_errors++;
		end
	endtask
	task automatic f(input logic [7:0] op, input int n, input int nr);
		@(negedge CLK);
		u_host.frame({op, 56'h0}, n, nr, rd);
	endtask
	task automatic idle();
		for (int i = 0; i < 2000 && STATUS[0] !== 1'b0; i++)
			wt(1);
	endtask
	task automatic finish_test();
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic s_basic();
		chk(STATUS, 24'h200000);
		chk({23'h0, STANDBY}, 24'h1);
		f(8'h75, 8, 0);
		wt(2);
		chk(STATUS, 24'h200000);
		f(8'h5A, 40, 16);
		chk({8'h0, rd}, 24'h5346);
		f(8'h03, 32, 8);
		chk({8'h0, rd}, 24'hFF);
		f(8'h0B, 40, 8);
		chk({8'h0, rd}, 24'hFF);
		f(8'hAB, 32, 16);
		chk({8'h0, rd}, 24'h3C3C);
		chk(24'(oe_cnt), 24'h30);
		wt(450);
	endtask
	task automatic s_prog();
		f(8'h02, 40, 0);
		wt(2);
		chk(STATUS, 24'h200001);
		chk({23'h0, STANDBY}, 24'h0);
		f(8'h7A, 8, 0);
		wt(2);
		chk(STATUS, 24'h200001);
		f(8'hAB, 32, 8);
		chk({8'h0, rd}, 24'h0);
		chk(24'(oe_cnt), 24'h30);
		f(8'h75, 8, 0);
		wt(1);
		chk(STATUS, 24'h208001);
		wt(1000);
		chk(STATUS, 24'h208000);
		f(8'h20, 32, 0);
		wt(5);
		chk(STATUS, 24'h208000);
		f(8'hC7, 8, 0);
		f(8'h42, 40, 0);
		wt(5);
		chk(STATUS, 24'h208000);
		f(8'h75, 8, 0);
		wt(5);
		chk(STATUS, 24'h208000);
		f(8'h7A, 8, 0);
		wt(1);
		chk(STATUS, 24'h200000);
		wt(12);
		chk(STATUS, 24'h200001);
		idle();
		chk(STATUS, 24'h200000);
	endtask
	task automatic s_erase();
		f(8'h20, 32, 0);
		wt(20);
		f(8'h75, 8, 0);
		wt(1);
		chk(STATUS, 24'h200401);
		wt(1000);
		f(8'h02, 40, 0);
		wt(2);
		chk(STATUS, 24'h200401);
		f(8'hB9, 8, 0);
		wt(200);
		chk({23'h0, DEEP_SLEEP}, 24'h0);
		idle();
		f(8'h01, 16, 0);
		wt(5);
		chk(STATUS, 24'h200400);
		f(8'h44, 32, 0);
		wt(5);
		chk(STATUS, 24'h200400);
		f(8'h7A, 8, 0);
		wt(14);
		chk(STATUS, 24'h200001);
		idle();
		chk(STATUS, 24'h200000);
	endtask
	task automatic s_sleep();
		f(8'hB9, 9, 0);
		wt(200);
		chk({23'h0, DEEP_SLEEP}, 24'h0);
		f(8'hB9, 8, 0);
		wt(100);
		chk({23'h0, DEEP_SLEEP}, 24'h0);
		wt(100);
		chk({23'h0, DEEP_SLEEP}, 24'h1);
		f(8'h02, 40, 0);
		wt(5);
		chk(STATUS, 24'h200000);
		f(8'hAB, 32, 16);
		chk({8'h0, rd}, 24'h3C3C);
		wt(2);
		chk({23'h0, DEEP_SLEEP}, 24'h0);
		wt(440);
		f(8'hB9, 8, 0);
		wt(200);
		f(8'hAB, 8, 0);
		wt(2);
		chk({23'h0, DEEP_SLEEP}, 24'h0);
		wt(150);
		f(8'h02, 40, 0);
		wt(2);
		chk(STATUS, 24'h200001);
		idle();
	endtask
	task automatic s_reset();
		f(8'h02, 40, 0);
		f(8'h66, 8, 0);
		f(8'h99, 8, 0);
		wt(2);
		chk(STATUS, 24'h200000);
		wt(1500);
		f(8'hB9, 8, 0);
		wt(200);
		chk({23'h0, DEEP_SLEEP}, 24'h1);
		f(8'h66, 8, 0);
		f(8'h99, 8, 0);
		wt(2);
		chk({23'h0, DEEP_SLEEP}, 24'h0);
		wt(1500);
		f(8'h02, 40, 0);
		wt(2);
		chk(STATUS, 24'h200001);
		idle();
	endtask
	// Hang guard, well above the cycles the run needs
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			finish_test();
		end
	end
	initial begin
		wt(16);
		RSTN = 1'b1;
		wt(4);
		s_basic();
		s_prog();
		s_erase();
		s_sleep();
		s_reset();
		finish_test();
	end
endmodule
`default_nettype wire
